// ---- src/hsdg_timers.sv ----
// Added by the designer: the Wishbone slave port and the address map.
`timescale 1ns/1ns
// Contract
// - Fixed 10 us filter on three comparators
// - Programmable enable delay before starting FET
// - Power-good assertion delay, 0 to 15 ms
// - Power-good deassertion delay, 0 to 15 ms
// - New current and voltage measurement every 102.4 us
// - Discharge timer starts with gate pull-down
// - Gate not discharged at expiry raises fault
// - Strong pull-down pulses for 15 us
module hsdg_timers #(
	parameter int MS_CYCLES = hsdg_pkg::MS_CYC,
	parameter int MEAS_CYCLES = hsdg_pkg::MEAS_CYC,
	parameter int DISCH_CYCLES = hsdg_pkg::DISCH_CYC
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic enable_undervoltage_input,
	input wire logic overvoltage_input,
	input wire logic feedback_input,
	input wire logic gate_below_limit_input,
	input wire logic discharge_start,
	output logic fet_start,
	output logic power_good_output,
	output logic strong_pulldown,
	output logic gate_discharge_stuck_fault,
	output logic current_meas_tick,
	output logic voltage_meas_tick,
	output logic overvoltage_filtered
);
	import hsdg_pkg::*;

	localparam int FIX_W = $clog2(FIX_DG_CYC + 1);

	// Enable-on delay in cycles: 0, then 4 ms doubling per code
	function automatic logic [31:0] en_delay(input logic [2:0] sel);
		logic [31:0] base;
		base = 32'(EN_DLY_BASE_MS * MS_CYCLES);
		en_delay = (sel == 3'h0) ? 32'h0000_0000 : (base << (sel - 3'h1));
	endfunction

	logic [2:0] sync1_q; // First stage, read only by the second
	logic [2:0] sync2_q;
	logic gate_low1_q;
	logic gate_low2_q;
	logic [2:0] filt_q; // {fb, ov, enable_undervoltage_input} after fixed filter
	logic [FIX_W-1:0] fcnt_q [3];
	logic [12:0] ctrl_q; // Software configuration
	logic [31:0] en_cnt_q;
	logic [31:0] en_lim;
	logic [31:0] pg_cnt_q;
	logic [31:0] pg_lim;
	logic [31:0] meas_cnt_q;
	logic disch_act_q;
	logic [31:0] disch_cnt_q;
	logic [31:0] spd_cnt_q;
	logic wb_req;
	logic sgd_clr;
	logic [31:0] rd_d;

	// Pin inputs pass two flops before any use
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sync1_q <= 3'h0;
			sync2_q <= 3'h0;
			gate_low1_q <= 1'b0;
			gate_low2_q <= 1'b0;
		end
		else
		begin
			sync1_q <= {feedback_input, overvoltage_input, enable_undervoltage_input};
			sync2_q <= sync1_q;
			gate_low1_q <= gate_below_limit_input;
			gate_low2_q <= gate_low1_q;
		end
	end

	// Fixed filters: output follows only after a full stable window
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			filt_q <= 3'h0;
			for (int i = 0; i < 3; i++)
				fcnt_q[i] <= '0;
		end
		else
		begin
			for (int i = 0; i < 3; i++)
			begin
				if (sync2_q[i] == filt_q[i])
					fcnt_q[i] <= '0; // Any bounce restarts the window
				else if (fcnt_q[i] == FIX_W'(FIX_DG_CYC - 1))
				begin
					filt_q[i] <= sync2_q[i];
					fcnt_q[i] <= '0;
				end
				else
					fcnt_q[i] <= fcnt_q[i] + 1'b1;
			end
		end
	end

	// Enable-on delay: counts while filtered enable is high
	assign en_lim = en_delay(ctrl_q[CTRL_EN_SEL_LSB +: 3]);
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			en_cnt_q <= 32'h0000_0000;
			fet_start <= 1'b0;
		end
		else
		begin
			if (!filt_q[ST_UVEN])
				en_cnt_q <= 32'h0000_0000; // Falling enable aborts the wait
			else if (en_cnt_q < en_lim)
				en_cnt_q <= en_cnt_q + 32'h0000_0001;
			// Compare with >= so a shortened setting cannot strand the count
			fet_start <= filt_q[ST_UVEN] && (en_cnt_q >= en_lim);
		end
	end

	// Power-good deglitch: delay depends on the edge being filtered
	assign pg_lim = 32'(MS_CYCLES) * (power_good_output
		? 32'(ctrl_q[CTRL_PGD_LSB +: 4]) : 32'(ctrl_q[CTRL_PGA_LSB +: 4]));
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pg_cnt_q <= 32'h0000_0000;
			power_good_output <= 1'b0;
		end
		else
		begin
			if (filt_q[ST_FB] == power_good_output)
				pg_cnt_q <= 32'h0000_0000;
			else if (pg_cnt_q + 32'h0000_0001 >= pg_lim)
			begin
				power_good_output <= filt_q[ST_FB];
				pg_cnt_q <= 32'h0000_0000;
			end
			else
				pg_cnt_q <= pg_cnt_q + 32'h0000_0001;
		end
	end

	// Measurement pacing: both converters start together
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			meas_cnt_q <= 32'h0000_0000;
			current_meas_tick <= 1'b0;
			voltage_meas_tick <= 1'b0;
		end
		else
		begin
			if (meas_cnt_q == 32'(MEAS_CYCLES - 1))
				meas_cnt_q <= 32'h0000_0000;
			else
				meas_cnt_q <= meas_cnt_q + 32'h0000_0001;
			current_meas_tick <= (meas_cnt_q == 32'(MEAS_CYCLES - 1));
			voltage_meas_tick <= (meas_cnt_q == 32'(MEAS_CYCLES - 1));
		end
	end

	// Gate discharge supervision and stuck-gate fault
	assign sgd_clr = wb_req && wb_we_i && (wb_adr_i == ADDR_STATUS) && wb_sel_i[0]
		&& wb_dat_i[ST_SGD];
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			disch_act_q <= 1'b0;
			disch_cnt_q <= 32'h0000_0000;
			gate_discharge_stuck_fault <= 1'b0;
		end
		else
		begin
			if (discharge_start)
			begin
				disch_act_q <= 1'b1;
				disch_cnt_q <= 32'h0000_0000;
			end
			else if (disch_act_q && gate_low2_q)
				disch_act_q <= 1'b0; // Gate discharged in time
			else if (disch_act_q && disch_cnt_q == 32'(DISCH_CYCLES - 1))
				disch_act_q <= 1'b0;
			else if (disch_act_q)
				disch_cnt_q <= disch_cnt_q + 32'h0000_0001;
			// Set wins over a software clear in the same cycle
			if (disch_act_q && !discharge_start && !gate_low2_q
				&& disch_cnt_q == 32'(DISCH_CYCLES - 1))
				gate_discharge_stuck_fault <= 1'b1;
			else if (sgd_clr)
				gate_discharge_stuck_fault <= 1'b0;
		end
	end

	// Strong pull-down pulse, only when configured
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			strong_pulldown <= 1'b0;
			spd_cnt_q <= 32'h0000_0000;
		end
		else
		begin
			if (discharge_start && ctrl_q[CTRL_STRONG_BIT])
			begin
				strong_pulldown <= 1'b1;
				spd_cnt_q <= 32'h0000_0000;
			end
			else if (strong_pulldown && spd_cnt_q == 32'(STRONG_PD_CYC - 1))
				strong_pulldown <= 1'b0;
			else if (strong_pulldown)
				spd_cnt_q <= spd_cnt_q + 32'h0000_0001;
		end
	end

	// Filtered overvoltage leaves the block from a flop
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			overvoltage_filtered <= 1'b0;
		else
			overvoltage_filtered <= filt_q[ST_OV];
	end

	// Wishbone slave: one wait state, unmapped reads return zero
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	always_comb
	begin
		rd_d = 32'h0000_0000;
		if (wb_adr_i == ADDR_CTRL)
			rd_d = {19'h0_0000, ctrl_q};
		else if (wb_adr_i == ADDR_STATUS)
			rd_d = {24'h00_0000, strong_pulldown, disch_act_q, gate_discharge_stuck_fault,
				power_good_output, fet_start, filt_q};
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
			ctrl_q <= CTRL_RST;
		end
		else
		begin
			wb_ack_o <= wb_req;
			wb_dat_o <= wb_req ? rd_d : 32'h0000_0000;
			if (wb_req && wb_we_i && wb_adr_i == ADDR_CTRL)
			begin
				if (wb_sel_i[0])
					ctrl_q[7:0] <= wb_dat_i[7:0];
				if (wb_sel_i[1])
					ctrl_q[12:8] <= wb_dat_i[12:8];
			end
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	fixed_dg_a: assert property (
		(filt_q[ST_OV] != $past(filt_q[ST_OV])) |-> $past(fcnt_q[ST_OV]) == FIX_W'(FIX_DG_CYC - 1))
		else $error("ov filter changed before full window");
	en_delay_a: assert property (
		$rose(fet_start) |-> $past(filt_q[ST_UVEN]) && $past(en_cnt_q) >= $past(en_lim))
		else $error("FET started before enable delay");
	en_drop_a: assert property (
		!filt_q[ST_UVEN] |=> !fet_start)
		else $error("FET start held without enable");
	pg_assert_a: assert property (
		$rose(power_good_output) |-> $past(pg_cnt_q) + 1 >= $past(pg_lim))
		else $error("power good asserted early");
	pg_deassert_a: assert property (
		$fell(power_good_output) |-> $past(pg_cnt_q) + 1 >= $past(pg_lim))
		else $error("power good deasserted early");
	meas_period_a: assert property (
		current_meas_tick |-> voltage_meas_tick ##1 !current_meas_tick [*2])
		else $error("measurement ticks out of step");
	disch_start_a: assert property (
		discharge_start |=> disch_act_q && disch_cnt_q == 0)
		else $error("discharge timer not started");
	sgd_raise_a: assert property (
		disch_act_q && !discharge_start && !gate_low2_q && disch_cnt_q == DISCH_CYCLES - 1
		|=> gate_discharge_stuck_fault && !disch_act_q)
		else $error("stuck gate fault not raised");
	strong_len_a: assert property (
		$fell(strong_pulldown) |-> $past(spd_cnt_q) == STRONG_PD_CYC - 1)
		else $error("strong pull-down width wrong");
	pg_hold_a: assert property (
		filt_q[ST_FB] != power_good_output && pg_cnt_q + 1 < pg_lim |=> $stable(power_good_output))
		else $error("power good moved inside deglitch");
	wb_ack_a: assert property (
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held for two cycles");

	fet_cov: cover property ($rose(fet_start));
	pg_cov: cover property ($fell(power_good_output));
	sgd_cov: cover property ($rose(gate_discharge_stuck_fault));
	strong_cov: cover property ($rose(strong_pulldown));
endmodule

// ---- src/hsdg_pkg.sv ----
package hsdg_pkg;
	// Clock and time base
	localparam int CLK_PERIOD_NS = 10;
	localparam int MS_NS = 1000000;
	localparam int MS_CYC = MS_NS / CLK_PERIOD_NS;
	// Fixed comparator deglitch, nominal 10 us
	localparam int FIX_DG_NS = 10000;
	localparam int FIX_DG_CYC = FIX_DG_NS / CLK_PERIOD_NS;
	// Measurement pacing, nominal 102.4 us
	localparam int MEAS_NS = 102400;
	localparam int MEAS_CYC = MEAS_NS / CLK_PERIOD_NS;
	// Gate discharge supervision, nominal 10 ms
	localparam int DISCH_MS = 10;
	localparam int DISCH_CYC = DISCH_MS * MS_CYC;
	// Strong pull-down pulse, nominal 15 us
	localparam int STRONG_PD_NS = 15000;
	localparam int STRONG_PD_CYC = STRONG_PD_NS / CLK_PERIOD_NS;
	// Enable-on delay base step for code 3'b001
	localparam int EN_DLY_BASE_MS = 4;
	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	// Control field positions and reset value
	localparam int CTRL_EN_SEL_LSB = 0;
	localparam int CTRL_PGA_LSB = 4;
	localparam int CTRL_PGD_LSB = 8;
	localparam int CTRL_STRONG_BIT = 12;
	localparam logic [12:0] CTRL_RST = 13'h0000;
	// Status bit positions
	localparam int ST_UVEN = 0;
	localparam int ST_OV = 1;
	localparam int ST_FB = 2;
	localparam int ST_FET = 3;
	localparam int ST_PG = 4;
	localparam int ST_SGD = 5;
	localparam int ST_DISCH = 6;
	localparam int ST_STRONG = 7;
endpackage

// ---- sim/hsdg_analog_model.sv ----
`timescale 1ns/1ns
// Stand-in for the comparators and the external gate
module hsdg_analog_model (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic en_lvl,
	input wire logic ov_lvl,
	input wire logic fb_lvl,
	input wire logic disch,
	input wire logic chg,
	input wire logic [7:0] fall_dly,
	output logic en_pin,
	output logic ov_pin,
	output logic fb_pin,
	output logic gate_below
);
	logic [7:0] cnt_q; // Cycles left before the gate falls
	// Comparators follow the commanded levels with no lag
	assign en_pin = en_lvl;
	assign ov_pin = ov_lvl;
	assign fb_pin = fb_lvl;
	// Gate is charged by chg ahead of a discharge, so the synchronised level
	// is already low when the timer starts; 8'hff models a stuck gate
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cnt_q <= 8'h00;
			gate_below <= 1'b1;
		end
		else if (disch)
		begin
			cnt_q <= fall_dly;
			gate_below <= 1'b0;
		end
		else if (chg)
		begin
			cnt_q <= 8'h00;
			gate_below <= 1'b0; // Driver has charged the gate
		end
		else if (cnt_q != 8'h00)
			cnt_q <= cnt_q - 8'h01;
		else if (fall_dly != 8'hff)
			gate_below <= 1'b1;
	end
endmodule

// ---- sim/hsdg_timers_tb.sv ----
`timescale 1ns/1ns
module hsdg_timers_tb;
	import hsdg_pkg::*;
	logic clk_sys, arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, dstart;
	logic [7:0] wb_adr_i, fall_dly;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic en_lvl, ov_lvl, fb_lvl, en_pin, ov_pin, fb_pin, gate_below, chg;
	logic fet, pg, spd, fault, ct, vt, ovf;
	logic [3:0] obs; // Watched levels by index
	int err_total, check_count, n;
	assign obs = {fault, ovf, fet, pg};
	// Short ms keeps the run brief, yet 15 ms must outlast the fixed filter
	localparam int MS = 80;
	// Short ms, pacing and discharge counts keep the run brief
	hsdg_timers #(.MS_CYCLES(MS), .MEAS_CYCLES(16), .DISCH_CYCLES(50)) u_dut (
		.clk_sys(clk_sys), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .enable_undervoltage_input(en_pin),
		.overvoltage_input(ov_pin), .feedback_input(fb_pin), .gate_below_limit_input(gate_below),
		.discharge_start(dstart), .fet_start(fet), .power_good_output(pg),
		.strong_pulldown(spd), .gate_discharge_stuck_fault(fault), .current_meas_tick(ct),
		.voltage_meas_tick(vt), .overvoltage_filtered(ovf));
	hsdg_analog_model u_ana (.clk_sys(clk_sys), .arst_n(arst_n), .en_lvl(en_lvl),
		.ov_lvl(ov_lvl), .fb_lvl(fb_lvl), .disch(dstart), .chg(chg), .fall_dly(fall_dly),
		.en_pin(en_pin), .ov_pin(ov_pin), .fb_pin(fb_pin), .gate_below(gate_below));
	// Free-running system clock
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		check_count++;
		if (e !== s)
		begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	// One classic cycle, entered just after an edge; the answer time is not assumed
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= s;
		@(posedge clk_sys);
		while (wb_ack_o !== 1'b1)
			@(posedge clk_sys); // Only the watchdog ends a lost answer
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_sys);
	endtask
	// Counts edges until a watched level takes a value
	task till(input int b, input logic v);
		n = 0;
		while (obs[b] !== v && n < 24000)
		begin
			n++;
			@(posedge clk_sys);
		end
	endtask
	task t_regs;
		wb(0, ADDR_CTRL, 0, 4'hf);
		chk("ctrl reset", 0, rd);
		wb(0, ADDR_STATUS, 0, 4'hf);
		chk("status reset", 0, rd);
		wb(1, ADDR_CTRL, 32'hffff_ffff, 4'hf);
		wb(0, ADDR_CTRL, 0, 4'hf);
		chk("ctrl fields", 32'h0000_1fff, rd);
		wb(0, 8'h08, 0, 4'hf);
		chk("unmapped", 0, rd);
		$display("test regs done");
	endtask
	// A short spike is dropped, a steady level passes after the fixed filter
	task t_filter;
		ov_lvl <= 1'b1;
		repeat (900) @(posedge clk_sys);
		ov_lvl <= 1'b0;
		n = 0;
		repeat (1200)
		begin
			@(posedge clk_sys);
			n += (ovf !== 1'b0);
		end
		chk("ov spike", 0, n);
		ov_lvl <= 1'b1;
		till(2, 1'b1);
		chk("ov steady", 1, n >= FIX_DG_CYC && n <= FIX_DG_CYC + 6);
		ov_lvl <= 1'b0;
		till(2, 1'b0);
		$display("test filter done");
	endtask
	// Every enable-on code, MS cycles to the ms
	task t_enable;
		int d;
		for (int k = 0; k < 8; k++)
		begin
			d = (k == 0) ? 0 : (4 << (k - 1)) * MS;
			wb(1, ADDR_CTRL, k, 4'h1);
			en_lvl <= 1'b1;
			till(1, 1'b1);
			chk("fet delay", 1, n >= d + FIX_DG_CYC && n <= d + FIX_DG_CYC + 8);
			en_lvl <= 1'b0;
			till(1, 1'b0);
			chk("fet drop", 1, n <= FIX_DG_CYC + 8);
		end
		$display("test enable done");
	endtask
	task t_pg;
		int lo;
		wb(1, ADDR_CTRL, 32'h0000_0f30, 4'h3);
		fb_lvl <= 1'b1;
		till(0, 1'b1);
		chk("pg assert", 1, n >= FIX_DG_CYC + 3 * MS && n <= FIX_DG_CYC + 3 * MS + 8);
		// A filtered dip of about 1100 cycles ends inside the 15 ms deassert delay
		fb_lvl <= 1'b0;
		repeat (1100) @(posedge clk_sys);
		fb_lvl <= 1'b1;
		lo = 0;
		repeat (1500)
		begin
			@(posedge clk_sys);
			lo += (pg !== 1'b1);
		end
		chk("pg dip held", 0, lo);
		wb(1, ADDR_CTRL, 32'h0000_0230, 4'h3);
		fb_lvl <= 1'b0;
		till(0, 1'b0);
		chk("pg deassert", 1, n >= FIX_DG_CYC + 2 * MS && n <= FIX_DG_CYC + 2 * MS + 8);
		$display("test pg done");
	endtask
	task t_meas;
		int c, v, b;
		c = 0;
		v = 0;
		b = 0;
		repeat (160)
		begin
			@(posedge clk_sys);
			c += (ct === 1'b1);
			v += (vt === 1'b1);
			b += (ct !== vt);
		end
		chk("current ticks", 10, c);
		chk("voltage ticks", 10, v);
		chk("ticks apart", 0, b);
		$display("test meas done");
	endtask
	// Pulses a discharge, then counts strong pull-down cycles and the fault moment
	task disch_run(input logic [7:0] dly, output int m, output int f);
		fall_dly <= dly;
		chg <= 1'b1;
		// Gate charged long enough for both sync stages to see it
		repeat (3) @(posedge clk_sys);
		chg <= 1'b0;
		dstart <= 1'b1;
		@(posedge clk_sys);
		dstart <= 1'b0;
		m = 0;
		f = 0;
		for (int i = 1; i <= 1600; i++)
		begin
			@(posedge clk_sys);
			m += (spd === 1'b1);
			if (fault === 1'b1 && f == 0)
				f = i;
		end
	endtask
	task t_disch;
		int m, f;
		wb(1, ADDR_CTRL, 0, 4'h3);
		disch_run(8'h0a, m, f);
		chk("no strong", 0, m);
		chk("no fault", 0, f);
		wb(1, ADDR_CTRL, 32'h0000_1000, 4'h3);
		disch_run(8'hff, m, f);
		chk("strong len", 1500, m);
		chk("fault time", 1, f >= 49 && f <= 56);
		wb(0, ADDR_STATUS, 0, 4'hf);
		chk("fault status", 1, rd[5]);
		wb(1, ADDR_STATUS, 32'h0000_0020, 4'h1);
		wb(0, ADDR_STATUS, 0, 4'hf);
		chk("fault clear", 0, rd[5]);
		$display("test discharge done");
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Tests take about 70k cycles; the limit sits at 90k
	initial
	begin
		#900000;
		err_total++;
		tally_and_finish;
	end
	initial
	begin
		arst_n = 1'b0;
		{wb_cyc_i, wb_stb_i, wb_we_i, dstart, en_lvl, ov_lvl, fb_lvl} = 7'h00;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0000_0000;
		fall_dly = 8'h00;
		chg = 1'b0;
		err_total = 0;
		check_count = 0;
		repeat (12) @(posedge clk_sys);
		arst_n <= 1'b1;
		@(posedge clk_sys);
		t_regs;
		t_filter;
		t_enable;
		t_pg;
		t_meas;
		t_disch;
		tally_and_finish;
	end
endmodule
